/* src/pwr_prot_pkg.sv */
// Contract
// - overcurrent turns switch off for the cycle, clears when command falls; in diode emulation the switch follows reverse current instead
// - short-circuit limit above overcurrent limit; detection latches switch off
// - latch holds until long command low or bias removed
// - short-circuit shutdown selects slowed turn-off drive
// - command frequency below threshold picks low peak limit, above picks high
// - five consecutive fast command cycles needed before high peak limit
// - high peak limit stays until power removed
// - transistor overtemperature enters diode emulation: off forward, on reverse
// - driver overtemperature shuts aux regulator, negative rail and switch
// - fault output low while either thermal shutdown active
// - exit only after both temperatures below falling trip points
// - leaving driver shutdown with transistor hot returns to diode emulation
// - undervoltage stops switching, holds switch off, fault low
// - current fault output low for overcurrent and short-circuit
// - fault output low at start-up until series transistor on
package pwr_prot_pkg;
    localparam int          SC_RESET_CYCLES = 1000;
    localparam int          FAST_PERIOD_MAX = 100;
    localparam int          FAST_CYCLES     = 5;
    localparam int          SERIES_ON_DELAY = 16;
    localparam logic [31:0] APB_CTRL        = 32'h0000_0000;
    localparam logic [31:0] APB_STATUS      = 32'h0000_0004;
    localparam logic [31:0] APB_IRQ_STAT    = 32'h0000_0008;
    localparam logic [31:0] APB_IRQ_MASK    = 32'h0000_000C;
    localparam logic [4:0]  IRQ_MASK_RST    = 5'h00;

    typedef enum logic [1:0] {
        TH_NORMAL = 2'b00,
        TH_DIODE  = 2'b01,
        TH_DRIVER = 2'b10
    } thermal_e;

    typedef struct packed {
        logic over_current;
        logic short_circuit;
        logic fet_hot;
        logic fet_cool;
        logic drv_hot;
        logic drv_cool;
        logic undervolt;
        logic reverse_current;
    } sense_s;

    typedef struct packed {
        logic      gate_on;
        logic      slow_turn_off;
        logic      high_peak_limit;
        logic      aux_5v_regulator_en;
        logic      negative_gate_rail_en;
        logic      fault_n;
        logic      current_trip_flag_n;
    } drive_s;
endpackage

/* src/sync2.sv */
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_r <= '0;
            q_o  <= '0;
        end else begin
            s1_r <= d_i;
            q_o  <= s1_r;
        end
    end
endmodule

/* src/power_switch_fault_protection.sv */
`timescale 1ns/1ps
module power_switch_fault_protection #(
    parameter int SC_RESET_CYCLES = pwr_prot_pkg::SC_RESET_CYCLES,
    parameter int FAST_PERIOD_MAX = pwr_prot_pkg::FAST_PERIOD_MAX
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  cmd_i,
    input  wire pwr_prot_pkg::sense_s  sense_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [31:0]           paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    output pwr_prot_pkg::drive_s       drive_o,
    output logic                       irq_o
);
    localparam int CW = $clog2(SC_RESET_CYCLES + 1);
    localparam int PW = $clog2(FAST_PERIOD_MAX + 2);

    logic                  cmd_s;
    pwr_prot_pkg::sense_s  sn;
    logic                  cmd_d_r;
    logic                  oc_r;
    logic                  sc_r;
    logic [CW-1:0]         low_cnt_r;
    logic [PW-1:0]         per_cnt_r;
    logic [2:0]            fast_cnt_r;
    logic                  high_lim_r;
    pwr_prot_pkg::thermal_e th_r;
    logic [4:0]            start_cnt_r;
    logic                  series_on_r;
    logic                  sw_enable_r;
    logic [4:0]            irq_stat_r;
    logic [4:0]            irq_mask_r;
    logic [4:0]            ev;
    logic                  rise;
    logic                  fall;
    logic                  lockout;
    logic                  gate_nxt;
    logic                  acc;
    logic                  wr;

    sync2 #(.W(9)) u_sync (
        .clk_i  (clk_i),
        .rst_n_i(rst_n_i),
        .d_i    ({cmd_i, sense_i}),
        .q_o    ({cmd_s, sn})
    );

    assign rise = cmd_s && !cmd_d_r;
    assign fall = !cmd_s && cmd_d_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmd_d_r <= 1'b0;
        end else begin
            cmd_d_r <= cmd_s;
        end
    end

    // per-cycle limit, released by command low
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            oc_r <= 1'b0;
        end else if (sn.over_current && cmd_s) begin
            oc_r <= 1'b1;
        end else if (!cmd_s) begin
            oc_r <= 1'b0;
        end
    end

    // low-time counter restarts on command high
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_cnt_r <= '0;
        end else if (cmd_s) begin
            low_cnt_r <= '0;
        end else if (low_cnt_r != CW'(SC_RESET_CYCLES)) begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sc_r <= 1'b0;
        end else if (sn.short_circuit) begin
            sc_r <= 1'b1;
        end else if (!cmd_s && low_cnt_r == CW'(SC_RESET_CYCLES)) begin
            // release only while the command is still low
            sc_r <= 1'b0;
        end
    end

    // frequency detector: period measured rise to rise
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            per_cnt_r  <= '0;
            fast_cnt_r <= '0;
        end else if (rise) begin
            per_cnt_r <= '0;
            if (per_cnt_r < PW'(FAST_PERIOD_MAX)) begin
                if (fast_cnt_r != 3'(pwr_prot_pkg::FAST_CYCLES)) begin
                    fast_cnt_r <= fast_cnt_r + 1'b1;
                end
            end else begin
                fast_cnt_r <= '0;
            end
        end else if (per_cnt_r != PW'(FAST_PERIOD_MAX)) begin
            per_cnt_r <= per_cnt_r + 1'b1;
        end else begin
            fast_cnt_r <= '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            high_lim_r <= 1'b0;
        end else if (fast_cnt_r == 3'(pwr_prot_pkg::FAST_CYCLES)) begin
            high_lim_r <= 1'b1;
        end
    end

    // thermal state machine
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            th_r <= pwr_prot_pkg::TH_NORMAL;
        end else begin
            case (th_r)
                pwr_prot_pkg::TH_NORMAL: begin
                    if (sn.drv_hot) begin
                        th_r <= pwr_prot_pkg::TH_DRIVER;
                    end else if (sn.fet_hot) begin
                        th_r <= pwr_prot_pkg::TH_DIODE;
                    end
                end
                pwr_prot_pkg::TH_DIODE: begin
                    if (sn.drv_hot) begin
                        th_r <= pwr_prot_pkg::TH_DRIVER;
                    end else if (sn.fet_cool && sn.drv_cool) begin
                        th_r <= pwr_prot_pkg::TH_NORMAL;
                    end
                end
                pwr_prot_pkg::TH_DRIVER: begin
                    if (sn.drv_cool && sn.fet_cool) begin
                        th_r <= pwr_prot_pkg::TH_NORMAL;
                    end else if (sn.drv_cool) begin
                        th_r <= pwr_prot_pkg::TH_DIODE;
                    end
                end
                default: th_r <= pwr_prot_pkg::TH_NORMAL;
            endcase
        end
    end

    // start-up: series transistor turned on after delay
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            start_cnt_r <= '0;
            series_on_r <= 1'b0;
        end else if (start_cnt_r != 5'(pwr_prot_pkg::SERIES_ON_DELAY)) begin
            start_cnt_r <= start_cnt_r + 1'b1;
        end else begin
            series_on_r <= 1'b1;
        end
    end

    assign lockout = sn.undervolt || th_r == pwr_prot_pkg::TH_DRIVER || !series_on_r
                     || !sw_enable_r;

    always_comb begin
        if (lockout) begin
            gate_nxt = 1'b0;
        end else if (sc_r || sn.short_circuit) begin
            gate_nxt = 1'b0;
        end else if (th_r == pwr_prot_pkg::TH_DIODE) begin
            gate_nxt = sn.reverse_current;
        end else if (oc_r || sn.over_current) begin
            gate_nxt = 1'b0;
        end else begin
            gate_nxt = cmd_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            drive_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        end else begin
            drive_o.gate_on               <= gate_nxt;
            drive_o.slow_turn_off         <= sc_r || sn.short_circuit;
            drive_o.high_peak_limit       <= high_lim_r;
            drive_o.aux_5v_regulator_en   <= th_r != pwr_prot_pkg::TH_DRIVER;
            drive_o.negative_gate_rail_en <= th_r != pwr_prot_pkg::TH_DRIVER;
            drive_o.fault_n <= !(sn.undervolt || th_r != pwr_prot_pkg::TH_NORMAL
                                 || sc_r || !series_on_r);
            drive_o.current_trip_flag_n <= !(oc_r || sc_r);
        end
    end

    // interrupts and apb slave
    assign ev  = {fall && oc_r, sc_r, th_r != pwr_prot_pkg::TH_NORMAL, sn.undervolt,
                  high_lim_r};
    assign acc = psel_i && penable_i;
    assign wr  = acc && pwrite_i;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_stat_r <= '0;
        end else if (wr && paddr_i == pwr_prot_pkg::APB_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~pwdata_i[4:0]) | ev;
        end else begin
            irq_stat_r <= irq_stat_r | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_mask_r  <= pwr_prot_pkg::IRQ_MASK_RST;
            sw_enable_r <= 1'b1;
        end else if (wr && paddr_i == pwr_prot_pkg::APB_IRQ_MASK) begin
            irq_mask_r <= pwdata_i[4:0];
        end else if (wr && paddr_i == pwr_prot_pkg::APB_CTRL) begin
            sw_enable_r <= pwdata_i[0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_o     <= 1'b0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            irq_o     <= |(irq_stat_r & irq_mask_r);
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
            if (psel_i && !penable_i) begin
                case (paddr_i)
                    pwr_prot_pkg::APB_CTRL:     prdata_o <= {31'h0, sw_enable_r};
                    pwr_prot_pkg::APB_STATUS:   prdata_o <= {24'h0, th_r, 1'b0, high_lim_r,
                                                  sc_r, oc_r, sn.undervolt, series_on_r};
                    pwr_prot_pkg::APB_IRQ_STAT: prdata_o <= {27'h0, irq_stat_r};
                    pwr_prot_pkg::APB_IRQ_MASK: prdata_o <= {27'h0, irq_mask_r};
                    default:                    pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    a_uv_gate_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sn.undervolt |=> !drive_o.gate_on) else $error("gate on under undervoltage");
    a_sc_latch_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sc_r ##1 sc_r |-> !drive_o.gate_on) else $error("gate on while latched");
    a_sc_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sc_r && cmd_s |=> sc_r) else $error("latch cleared with command high");
    a_sc_slow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sc_r |=> drive_o.slow_turn_off) else $error("slow turn-off missing");
    a_lim_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        high_lim_r |=> high_lim_r) else $error("peak limit fell back");
    a_lim_needs_five: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(high_lim_r) |-> $past(fast_cnt_r) == 3'(pwr_prot_pkg::FAST_CYCLES))
        else $error("limit raised early");
    a_th_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        th_r != pwr_prot_pkg::TH_NORMAL |=> !drive_o.fault_n)
        else $error("fault high in thermal shutdown");
    a_drv_rails_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        th_r == pwr_prot_pkg::TH_DRIVER |=> !drive_o.aux_5v_regulator_en
        && !drive_o.negative_gate_rail_en && !drive_o.gate_on)
        else $error("rails on in driver shutdown");
    a_oc_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        oc_r |=> !drive_o.current_trip_flag_n) else $error("current flag missing");
    a_oc_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        oc_r && !cmd_s |=> !oc_r) else $error("overcurrent not released");
    a_start_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !series_on_r |=> !drive_o.fault_n) else $error("fault high at start-up");
    // fault reporting, diode emulation, enable guards and thermal exit
    a_diode_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        th_r == pwr_prot_pkg::TH_DIODE && !sn.reverse_current |=> !drive_o.gate_on)
        else $error("gate on against forward current");
    a_uv_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sn.undervolt |=> !drive_o.fault_n)
        else $error("fault high under undervoltage");
    a_sc_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sc_r |=> !drive_o.current_trip_flag_n && !drive_o.fault_n)
        else $error("short-circuit not reported");
    a_oc_fault_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        oc_r && !sc_r && series_on_r && !sn.undervolt && th_r == pwr_prot_pkg::TH_NORMAL
        |=> drive_o.fault_n) else $error("fault low for overcurrent alone");
    a_disable_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !sw_enable_r |=> !drive_o.gate_on)
        else $error("gate on while disabled");
    a_cool_exit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        th_r != pwr_prot_pkg::TH_NORMAL && !(sn.fet_cool && sn.drv_cool)
        |=> th_r != pwr_prot_pkg::TH_NORMAL) else $error("thermal exit too early");
endmodule

/* dv/pwr_ctrl_model.sv */
`timescale 1ns/1ps
module pwr_ctrl_model (
    input  wire logic clk_i,
    output logic      cmd_o
);
    // command stays low through reset, before any request is allowed
    initial cmd_o = 1'h0;

    task automatic set_level(input logic lvl);
        @(posedge clk_i);
        cmd_o <= lvl;
    endtask

    // long low time is what clears a latched short-circuit shutdown
    task automatic hold_low(input int cycles);
        set_level(1'h0);
        repeat (cycles) @(posedge clk_i);
    endtask

    // n command periods of 2*half cycles each, ending low
    task automatic pulses(input int n, input int half);
        repeat (n) begin
            set_level(1'h1);
            repeat (half) @(posedge clk_i);
            cmd_o <= 1'h0;
            repeat (half - 1) @(posedge clk_i);
        end
    endtask
endmodule

/* dv/power_switch_fault_protection_tb.sv */
`timescale 1ns/1ps
module power_switch_fault_protection_tb;
    localparam int SC_CYC   = 20;
    localparam int FAST_MAX = 10;
    localparam logic [7:0] IDLE = 8'h14;
    logic                 clk_i;
    logic                 rst_n_i;
    logic                 cmd;
    pwr_prot_pkg::sense_s sense;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [31:0]          paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    pwr_prot_pkg::drive_s drv;
    logic                 irq;
    logic [31:0]          rd;
    logic                 err;
    logic                 irq_a;
    int                   num_errors;
    int                   samples_checked;

    power_switch_fault_protection #(
        .SC_RESET_CYCLES(SC_CYC),
        .FAST_PERIOD_MAX(FAST_MAX)
    ) i_dut (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .cmd_i    (cmd),
        .sense_i  (sense),
        .psel_i   (psel),
        .penable_i(penable),
        .pwrite_i (pwrite),
        .paddr_i  (paddr),
        .pwdata_i (pwdata),
        .prdata_o (prdata),
        .pready_o (pready),
        .pslverr_o(pslverr),
        .drive_o  (drv),
        .irq_o    (irq)
    );

    pwr_ctrl_model i_ctrl (
        .clk_i(clk_i),
        .cmd_o(cmd)
    );

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic set_sense(input logic [7:0] v);
        @(posedge clk_i);
        sense <= pwr_prot_pkg::sense_s'(v);
    endtask

    // setup cycle, then access held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel   <= 1'h1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd  = prdata;
        err = pslverr;
        if (pready !== 1'h1) chk("pready", 32'h0, 32'h1);
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end

    initial begin
        rst_n_i = 1'h0;
        sense = pwr_prot_pkg::sense_s'(IDLE);
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        num_errors = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'h1;
        settle(2);
        chk("gft start", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h1);
        settle(30);
        chk("gft series on", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h3);
        apb(1'h0, pwr_prot_pkg::APB_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h1);
        apb(1'h0, 32'h0000_0010, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        $display("test startup done");

        i_ctrl.set_level(1'h1);
        settle(6);
        chk("gft cmd", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h7);
        set_sense(8'h94);
        settle(6);
        chk("gft oc", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h2);
        set_sense(IDLE);
        settle(6);
        chk("gate oc rest", {31'h0, drv.gate_on}, 32'h0);
        i_ctrl.set_level(1'h0);
        settle(8);
        chk("gft oc clear", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h3);
        i_ctrl.set_level(1'h1);
        settle(6);
        chk("gft next", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h7);
        $display("test overcurrent done");

        set_sense(8'h54);
        settle(6);
        chk("gft sc", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h0);
        chk("slow off", {31'h0, drv.slow_turn_off}, 32'h1);
        set_sense(IDLE);
        i_ctrl.hold_low(12);
        i_ctrl.set_level(1'h1);
        settle(6);
        chk("gft short low", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h0);
        i_ctrl.hold_low(12);
        i_ctrl.set_level(1'h1);
        settle(6);
        chk("gft restart", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h0);
        i_ctrl.hold_low(SC_CYC + 10);
        i_ctrl.set_level(1'h1);
        settle(6);
        chk("gft sc reset", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h7);
        $display("test short circuit done");

        set_sense(8'h24);
        settle(6);
        chk("gft fet hot", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h1);
        apb(1'h0, pwr_prot_pkg::APB_STATUS, 32'h0);
        chk("status diode", rd, 32'h41);
        set_sense(8'h25);
        settle(6);
        chk("gft reverse", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h5);
        set_sense(8'h29);
        settle(6);
        chk("gft drv hot", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h1);
        chk("rails drv hot", {drv.aux_5v_regulator_en, drv.negative_gate_rail_en}, 2'h0);
        set_sense(8'h25);
        settle(6);
        chk("gft drv cool", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h5);
        set_sense(8'h04);
        settle(6);
        chk("gft band", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h1);
        set_sense(IDLE);
        settle(6);
        chk("gft cool", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h7);
        chk("rails cool", {drv.aux_5v_regulator_en, drv.negative_gate_rail_en}, 2'h3);
        set_sense(8'h16);
        settle(6);
        chk("gft uv", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h1);
        set_sense(IDLE);
        settle(6);
        chk("gft uv end", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h7);
        apb(1'h1, pwr_prot_pkg::APB_CTRL, 32'h0);
        settle(4);
        chk("gft disabled", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h3);
        apb(1'h1, pwr_prot_pkg::APB_CTRL, 32'h1);
        settle(4);
        chk("gft enabled", {drv.gate_on, drv.fault_n, drv.current_trip_flag_n}, 3'h7);
        $display("test thermal and supply done");

        i_ctrl.hold_low(20);
        i_ctrl.pulses(4, 15);
        settle(4);
        chk("limit slow", {31'h0, drv.high_peak_limit}, 32'h0);
        i_ctrl.pulses(4, 3);
        settle(10);
        chk("limit 3 fast", {31'h0, drv.high_peak_limit}, 32'h0);
        i_ctrl.pulses(8, 3);
        settle(6);
        chk("limit 7 fast", {31'h0, drv.high_peak_limit}, 32'h1);
        i_ctrl.pulses(3, 15);
        settle(4);
        chk("limit kept", {31'h0, drv.high_peak_limit}, 32'h1);
        $display("test peak limit done");

        apb(1'h0, pwr_prot_pkg::APB_IRQ_STAT, 32'h0);
        chk("irq stat", rd, 32'h1F);
        apb(1'h0, pwr_prot_pkg::APB_STATUS, 32'h0);
        chk("status limit", rd, 32'h11);
        settle(2);
        irq_a = irq;
        apb(1'h1, pwr_prot_pkg::APB_IRQ_MASK, 32'h1F);
        apb(1'h0, pwr_prot_pkg::APB_IRQ_MASK, 32'h0);
        chk("mask rb", rd, 32'h1F);
        settle(2);
        chk("irq masked", {31'h0, irq_a}, 32'h0);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        apb(1'h1, pwr_prot_pkg::APB_IRQ_STAT, 32'h1F);
        apb(1'h0, pwr_prot_pkg::APB_IRQ_STAT, 32'h0);
        chk("irq w1c", rd, 32'h1);
        $display("test interrupt done");

        rst_n_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'h1;
        settle(30);
        chk("limit power off", {31'h0, drv.high_peak_limit}, 32'h0);
        $display("test reset done");
        print_verdict();
    end
endmodule
